// File: cpt_target_port.sv
// PMBus target port: bus engine, command decode, fault alert
//
// Contract
// - Bus clock is 100 or 400 kHz only.
// - Address is eight times high index plus low.
// - Resistor series maps each pin to 0..7.
// - Addresses 0, 11, 12 become 127.
// - Option lets only high pin set address.
// - Standard protocol; device may stretch clock.
// - Busy flag reported in status responses.
// - Protection faults assert the alert line.
// - Read commands return the six measurements.
// - Temperature read follows sensor select command.
// - Settings kept and rewritable over the link.
// - Behaves as PMBus 1.3 compatible target.
// - Alert stays until clear faults or re-enable; masking all latched faults also drops it.
// - Alert mask suppresses chosen fault sources.
`timescale 1ns/1ns
module cpt_target_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus pins, open drain
  input wire logic i_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_oe,
  // Fault alert line, open drain, driven low when set
  output logic o_fault_alert_line_oe,
  // Address select level codes
  input wire logic [7:0] i_address_select_high,
  input wire logic [7:0] i_address_select_low,
  input wire logic i_single_pin_address_option,
  // Converter status and faults
  input wire logic i_busy,
  input wire logic [6:0] i_fault_events,
  input wire logic i_vout_reenable,
  // Measurements
  input wire logic [15:0] i_vin,
  input wire logic [15:0] i_vout,
  input wire logic [15:0] i_iout,
  input wire logic [15:0] i_temp_int,
  input wire logic [15:0] i_temp_ext,
  input wire logic [15:0] i_freq,
  input wire logic [15:0] i_duty,
  // Setting writes toward the non-volatile store, then the captured own address
  output logic o_cfg_wr,
  output logic [7:0] o_cfg_cmd,
  output logic [15:0] o_cfg_data,
  output logic o_store_req,
  output logic [6:0] o_addr,
  output logic o_addr_valid
);
  cpt_pkg::cpt_regs_t r_q, r_d;
  logic [15:0] cfg_mem [256];
  logic [6:0] own_addr;
  logic addr_valid;

  cpt_addr_decode u_addr (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_sel_high_code(i_address_select_high),
    .i_sel_low_code(i_address_select_low),
    .i_single_pin(i_single_pin_address_option | r_q.single_pin),
    .o_addr(own_addr),
    .o_valid(addr_valid)
  );

  function automatic logic [15:0] swap_bytes(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  logic scl_h, sda_h, scl_rise, scl_fall, start_c, stop_c;
  logic [15:0] resp;
  localparam int NUM_FAULTS_W = cpt_pkg::NUM_FAULTS;
  logic [7:0] status_byte;
  logic [NUM_FAULTS_W-1:0] clr_faults;

  // Edges come from the second and third stages only
  assign scl_h = r_q.scl_s[1];
  assign sda_h = r_q.sda_s[1];
  assign scl_rise = scl_h & ~r_q.scl_s[2];
  assign scl_fall = ~scl_h & r_q.scl_s[2];
  assign start_c = scl_h & r_q.scl_s[2] & ~sda_h & r_q.sda_s[2];
  assign stop_c = scl_h & r_q.scl_s[2] & sda_h & ~r_q.sda_s[2];

  always_comb
  begin
    status_byte = {i_busy, r_q.sticky};
    case (r_q.cmd)
      cpt_pkg::CMD_READ_VIN: resp = i_vin;
      cpt_pkg::CMD_READ_VOUT: resp = i_vout;
      cpt_pkg::CMD_READ_IOUT: resp = i_iout;
      cpt_pkg::CMD_READ_TEMP:
        resp = r_q.temp_sel ? i_temp_ext : i_temp_int;
      cpt_pkg::CMD_READ_FREQ: resp = i_freq;
      cpt_pkg::CMD_READ_DUTY: resp = i_duty;
      cpt_pkg::CMD_STATUS_BYTE: resp = {8'h00, status_byte};
      cpt_pkg::CMD_STATUS_WORD: resp = {8'h00, status_byte};
      cpt_pkg::CMD_ALERT_MASK: resp = {9'h000, r_q.mask};
      cpt_pkg::CMD_PMBUS_REV: resp = {8'h00, cpt_pkg::PMBUS_REV_1_3};
      default: resp = cfg_mem[r_q.cmd];
    endcase
  end

  always_comb
  begin
    r_d = r_q;
    r_d.scl_s = {r_q.scl_s[1:0], i_scl};
    r_d.sda_s = {r_q.sda_s[1:0], i_sda};
    r_d.wr_pulse = 1'b0;
    r_d.store_pulse = 1'b0;
    clr_faults = '0;
    case (r_q.st)
      cpt_pkg::ST_IDLE:
      begin
        r_d.sda_oe = 1'b0;
      end
      cpt_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          r_d.sh = {r_q.sh[6:0], sda_h};
          r_d.bitcnt = r_q.bitcnt + 4'h1;
        end
        else if (scl_fall && r_q.bitcnt == cpt_pkg::BITS_PER_BYTE)
        begin
          r_d.st = cpt_pkg::ST_RACK;
          r_d.sda_oe = 1'b1;
          if (r_q.ph == cpt_pkg::PH_ADDR)
          begin
            r_d.rw = r_q.sh[0];
            r_d.tx = swap_bytes(resp);
            if (!addr_valid || r_q.sh[7:1] != own_addr)
            begin
              r_d.st = cpt_pkg::ST_IDLE;
              r_d.sda_oe = 1'b0;
            end
          end
          else if (r_q.ph == cpt_pkg::PH_CMD)
          begin
            r_d.cmd = r_q.sh;
            r_d.nbytes = 2'h0;
          end
          else if (r_q.nbytes != cpt_pkg::WORD_BYTES)
          begin
            r_d.wdata = {r_q.sh, r_q.wdata[15:8]};
            r_d.nbytes = r_q.nbytes + 2'h1;
          end
        end
      end
      cpt_pkg::ST_RACK:
      begin
        if (scl_fall)
        begin
          r_d.sda_oe = 1'b0;
          r_d.bitcnt = 4'h0;
          // Hold clock low while the converter cannot serve us
          r_d.scl_oe = i_busy;
          if (r_q.ph == cpt_pkg::PH_ADDR && r_q.rw)
          begin
            r_d.st = cpt_pkg::ST_TX;
            r_d.sda_oe = ~r_q.tx[15];
          end
          else
          begin
            r_d.st = cpt_pkg::ST_RX;
            if (r_q.ph != cpt_pkg::PH_DATA)
              r_d.ph = cpt_pkg::cpt_phase_t'(r_q.ph + 2'h1);
          end
        end
      end
      cpt_pkg::ST_TX:
      begin
        if (scl_fall)
        begin
          if (r_q.bitcnt == cpt_pkg::BITS_PER_BYTE - 4'h1)
          begin
            r_d.st = cpt_pkg::ST_TACK;
            r_d.sda_oe = 1'b0;
            r_d.tx = {r_q.tx[14:0], 1'b1};
          end
          else
          begin
            r_d.bitcnt = r_q.bitcnt + 4'h1;
            r_d.tx = {r_q.tx[14:0], 1'b1};
            r_d.sda_oe = ~r_q.tx[14];
          end
        end
      end
      cpt_pkg::ST_TACK:
      begin
        if (scl_rise)
          r_d.nack = sda_h;
        else if (scl_fall)
        begin
          r_d.bitcnt = 4'h0;
          r_d.st = r_q.nack ? cpt_pkg::ST_IDLE : cpt_pkg::ST_TX;
          r_d.sda_oe = ~r_q.nack & ~r_q.tx[15];
        end
      end
      default:
      begin
        r_d.st = cpt_pkg::ST_IDLE;
        r_d.sda_oe = 1'b0;
      end
    endcase
    if (r_q.scl_oe && !i_busy)
      r_d.scl_oe = 1'b0;
    if (start_c)
    begin
      r_d.st = cpt_pkg::ST_RX;
      r_d.ph = cpt_pkg::PH_ADDR;
      r_d.bitcnt = 4'h0;
      r_d.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      r_d.st = cpt_pkg::ST_IDLE;
      r_d.sda_oe = 1'b0;
      r_d.scl_oe = 1'b0;
      if (r_q.ph == cpt_pkg::PH_DATA && !r_q.rw)
      begin
        if (r_q.nbytes == 2'h0)
        begin
          if (r_q.cmd == cpt_pkg::CMD_CLEAR_FAULTS)
            clr_faults = '1;
          if (r_q.cmd == cpt_pkg::CMD_STORE_USER_ALL)
            r_d.store_pulse = 1'b1;
        end
        else
        begin
          // A single data byte lands in the low half
          r_d.wr_data = (r_q.nbytes == cpt_pkg::WORD_BYTES) ? r_q.wdata
            : {8'h00, r_q.wdata[15:8]};
          r_d.wr_cmd = r_q.cmd;
          r_d.wr_pulse = 1'b1;
          if (r_q.cmd == cpt_pkg::CMD_ALERT_MASK)
            r_d.mask = r_d.wr_data[NUM_FAULTS_W-1:0];
          if (r_q.cmd == cpt_pkg::CMD_TEMP_SELECT)
            r_d.temp_sel = r_d.wr_data[cpt_pkg::TEMP_SEL_BIT];
          if (r_q.cmd == cpt_pkg::CMD_SINGLE_PIN)
            r_d.single_pin = r_d.wr_data[cpt_pkg::SINGLE_PIN_BIT];
        end
      end
    end
    if (i_vout_reenable)
      clr_faults = '1;
    // New fault wins over a clear in the same cycle
    r_d.sticky = (r_q.sticky & ~clr_faults) | i_fault_events;
    r_d.alert_oe = |(r_d.sticky & ~r_d.mask);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r_q <= '0;
      r_q.scl_s <= 3'h7;
      r_q.sda_s <= 3'h7;
      r_q.st <= cpt_pkg::ST_IDLE;
    end
    else
      r_q <= r_d;
  end

  // Working copy of settings; no reset, contents come only from link writes
  always_ff @(posedge i_clk)
  begin
    if (r_q.wr_pulse)
      cfg_mem[r_q.wr_cmd] <= r_q.wr_data;
  end

  assign o_scl_oe = r_q.scl_oe;
  assign o_sda_oe = r_q.sda_oe;
  assign o_fault_alert_line_oe = r_q.alert_oe;
  assign o_cfg_wr = r_q.wr_pulse;
  assign o_cfg_cmd = r_q.wr_cmd;
  assign o_cfg_data = r_q.wr_data;
  assign o_store_req = r_q.store_pulse;
  assign o_addr = own_addr;
  assign o_addr_valid = addr_valid;
endmodule // cpt_target_port

// File: cpt_pkg_addr.sv
// Shared constants plus the address-select decoder of the target port
`timescale 1ns/1ns
package cpt_pkg;
  // Bus rates the port is built for, in kHz
  localparam int BUS_RATE_STD_KHZ = 100;
  localparam int BUS_RATE_FAST_KHZ = 400;
  localparam int CLK_MHZ = 100;
  // Oversampling per bit period at the fastest supported rate, fast mode
  localparam int SAMPLES_PER_BIT = (CLK_MHZ * 1000) / BUS_RATE_FAST_KHZ;

  // Address forming
  localparam logic [6:0] ADDR_HIGH_WEIGHT = 7'h08;
  localparam logic [6:0] ADDR_BAD_A = 7'h00;
  localparam logic [6:0] ADDR_BAD_B = 7'h0b;
  localparam logic [6:0] ADDR_BAD_C = 7'h0c;
  localparam logic [6:0] ADDR_FALLBACK = 7'h7f;
  localparam logic [2:0] INIT_WAIT = 3'h4;

  // Pin level code thresholds between neighbouring resistors
  // (10k, 22k, 33k, 47k, 68k, 100k, 150k, 220k -> index 0..7)
  localparam int NUM_THR = 7;
  // Packed so that element 0 is the lowest threshold
  localparam logic [NUM_THR-1:0][7:0] SEL_THR = {
    8'hc0, 8'h98, 8'h78, 8'h58, 8'h40, 8'h2c, 8'h18};

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CMD_READ_DUTY = 8'h94;
  localparam logic [7:0] CMD_READ_FREQ = 8'h95;
  localparam logic [7:0] CMD_PMBUS_REV = 8'h98;
  localparam logic [7:0] CMD_TEMP_SELECT = 8'hdc;
  localparam logic [7:0] CMD_SINGLE_PIN = 8'hc9;
  localparam logic [7:0] PMBUS_REV_1_3 = 8'h33;

  // Field positions
  localparam int BUSY_BIT = 7;
  localparam int TEMP_SEL_BIT = 0;
  localparam int SINGLE_PIN_BIT = 0;
  localparam int NUM_FAULTS = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] WORD_BYTES = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_RACK = 5'h04,
    ST_TX = 5'h08,
    ST_TACK = 5'h10
  } cpt_state_e_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_CMD = 2'h1,
    PH_DATA = 2'h2
  } cpt_phase_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    cpt_state_e_t st;
    cpt_phase_t ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [7:0] cmd;
    logic [1:0] nbytes;
    logic [15:0] wdata;
    logic [15:0] tx;
    logic sda_oe;
    logic scl_oe;
    logic [NUM_FAULTS-1:0] sticky;
    logic [NUM_FAULTS-1:0] mask;
    logic temp_sel;
    logic single_pin;
    logic alert_oe;
    logic wr_pulse;
    logic store_pulse;
    logic [7:0] wr_cmd;
    logic [15:0] wr_data;
  } cpt_regs_t;
endpackage

module cpt_addr_decode (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Select pin level codes
  input wire logic [7:0] i_sel_high_code,
  input wire logic [7:0] i_sel_low_code,
  input wire logic i_single_pin,
  // Result
  output logic [6:0] o_addr,
  output logic o_valid
);
  typedef struct packed {
    logic [7:0] hi1;
    logic [7:0] hi2;
    logic [7:0] lo1;
    logic [7:0] lo2;
    logic [2:0] cnt;
    logic [6:0] addr;
    logic valid;
  } cpt_dec_t;

  cpt_dec_t r_q, r_d;

  function automatic logic [2:0] sel_index(input logic [7:0] code);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 0; k < cpt_pkg::NUM_THR; k++)
    begin
      if (code >= cpt_pkg::SEL_THR[k])
        idx = 3'(k + 1);
    end
    return idx;
  endfunction

  logic [6:0] calc;

  always_comb
  begin
    if (i_single_pin)
      calc = 7'(cpt_pkg::ADDR_HIGH_WEIGHT * sel_index(r_q.hi2));
    else
      calc = 7'(cpt_pkg::ADDR_HIGH_WEIGHT * sel_index(r_q.hi2)
        + 7'(sel_index(r_q.lo2)));
    if (calc == cpt_pkg::ADDR_BAD_A || calc == cpt_pkg::ADDR_BAD_B ||
        calc == cpt_pkg::ADDR_BAD_C)
      calc = cpt_pkg::ADDR_FALLBACK;
    r_d = r_q;
    r_d.hi1 = i_sel_high_code;
    r_d.hi2 = r_q.hi1;
    r_d.lo1 = i_sel_low_code;
    r_d.lo2 = r_q.lo1;
    // Caught once after reset, then frozen until the next reset
    if (!r_q.valid)
    begin
      if (r_q.cnt == cpt_pkg::INIT_WAIT)
      begin
        r_d.addr = calc;
        r_d.valid = 1'b1;
      end
      else
        r_d.cnt = r_q.cnt + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign o_addr = r_q.addr;
  assign o_valid = r_q.valid;
endmodule // cpt_addr_decode

// File: cpt_target_port_properties.sv
// Pin-level checks on the target port
`timescale 1ns/1ns
module cpt_target_port_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus and alert
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_fault_alert_line_oe,
  // Address select
  input wire logic [7:0] i_address_select_high,
  input wire logic [7:0] i_address_select_low,
  input wire logic i_single_pin_address_option,
  // Converter side
  input wire logic i_busy,
  input wire logic [6:0] i_fault_events,
  input wire logic i_vout_reenable,
  input wire logic o_cfg_wr,
  input wire logic [7:0] o_cfg_cmd,
  input wire logic [15:0] o_cfg_data,
  input wire logic o_store_req,
  input wire logic [6:0] o_addr,
  input wire logic o_addr_valid
);
  logic [6:0] mask_q;
  logic [3:0] stop_q;
  logic [1:0] sda_q;
  function automatic logic [6:0] exp_addr(input logic [7:0] h, l,
    input logic sp);
    logic [6:0] a;
    logic [2:0] ih;
    logic [2:0] il;
    ih = 3'h0;
    il = 3'h0;
    for (int k = 0; k < cpt_pkg::NUM_THR; k++)
    begin
      ih = ih + 3'(h >= cpt_pkg::SEL_THR[k]);
      il = il + 3'(l >= cpt_pkg::SEL_THR[k]);
    end
    a = sp ? {1'b0, ih, 3'h0} : {1'b0, ih, il};
    if (a == 7'h00 || a == 7'h0b || a == 7'h0c)
      a = 7'h7f;
    return a;
  endfunction
  // Mask mirrored from write pulses, since it is not visible
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mask_q <= 7'h00;
      stop_q <= 4'hf;
      sda_q <= 2'h3;
    end
    else
    begin
      sda_q <= {sda_q[0], i_sda};
      if (o_cfg_wr && o_cfg_cmd == cpt_pkg::CMD_ALERT_MASK)
        mask_q <= o_cfg_data[6:0];
      if (sda_q == 2'h1 && i_scl)
        stop_q <= 4'h0;
      else if (stop_q != 4'hf)
        stop_q <= stop_q + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_addr_formula: assert property ($rose(o_addr_valid) |->
    o_addr == exp_addr(i_address_select_high, i_address_select_low,
    i_single_pin_address_option)) else $error("bad own address");
  a_addr_frozen: assert property (o_addr_valid && $past(o_addr_valid)
    |-> $stable(o_addr)) else $error("address moved");
  a_addr_timely: assert property ($rose(i_resetn) |->
    ##[1:8] o_addr_valid) else $error("address not captured");
  a_no_early_ack: assert property (!o_addr_valid |-> !o_sda_oe)
    else $error("answer before address known");
  a_alert_raise: assert property ((i_fault_events & ~mask_q) != 7'h00
    |-> ##[1:2] o_fault_alert_line_oe) else $error("alert missing");
  a_alert_kept: assert property ($fell(o_fault_alert_line_oe) |->
    stop_q < 4'hc || $past(i_vout_reenable) || $past(i_vout_reenable, 2))
    else $error("alert dropped without clear");
  a_reenable_clr: assert property ((i_vout_reenable &&
    i_fault_events == 7'h00) ##1 i_fault_events == 7'h00 |->
    ##[0:1] !o_fault_alert_line_oe) else $error("alert not cleared");
  a_cfg_pulse: assert property (o_cfg_wr |-> stop_q < 4'hc
    ##1 !o_cfg_wr) else $error("setting write off stop");
  a_store_pulse: assert property (o_store_req |-> stop_q < 4'hc
    ##1 !o_store_req) else $error("store request off stop");
  a_stretch_free: assert property (o_scl_oe && !i_busy |=> !o_scl_oe)
    else $error("clock held while idle");
  c_stretch: cover property (o_scl_oe);
  c_alert: cover property ($rose(o_fault_alert_line_oe));
  c_store: cover property (o_store_req);
endmodule // cpt_target_port_properties

bind cpt_target_port cpt_target_port_properties u_props (
  .i_clk, .i_resetn, .i_scl, .i_sda, .o_scl_oe, .o_sda_oe,
  .o_fault_alert_line_oe, .i_address_select_high, .i_address_select_low,
  .i_single_pin_address_option, .i_busy, .i_fault_events,
  .i_vout_reenable, .o_cfg_wr, .o_cfg_cmd, .o_cfg_data, .o_store_req,
  .o_addr, .o_addr_valid
);

// File: cpt_host.sv
// Behavioural bus host on the open-drain management link
`timescale 1ns/1ns
module cpt_host #(
  parameter int BUS_FREE_NS = 1300,
  parameter int STORE_WAIT_NS = 5000000
) (
  // Resolved line levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-down enables
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial
  begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Bounded, so a stuck clock ends in the bench timeout
  task automatic scl_up();
    int n;
    o_scl_oe = 1'b0;
    n = 0;
    // Fixed settle step keeps the bit period at 125 ns
    #10;
    while (i_scl !== 1'b1 && n < 20000)
      #10 n++;
  endtask
  // Data moves 20 ns after the fall, clear of the sync skew
  task automatic bit_io(input logic b, output logic r);
    #20 o_sda_oe = !b;
    #45 scl_up();
    #25 r = i_sda;
    #25 o_scl_oe = 1'b1;
  endtask
  task automatic start_cond();
    #20 o_sda_oe = 1'b0;
    #45 scl_up();
    #60 o_sda_oe = 1'b1;
    #60 o_scl_oe = 1'b1;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a,
    output logic [7:0] q, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a, r);
    ok = !r;
  endtask
  // No error-check byte: the target has no checker for one
  task automatic xfer(input logic [6:0] a, input logic [7:0] c,
    input logic [1:0] nd, input logic [15:0] d, input logic rd,
    output logic [15:0] q, output logic ack);
    logic [7:0] lo;
    logic [7:0] hi;
    logic k;
    start_cond();
    byte_io({a, 1'b0}, 1'b1, lo, ack);
    byte_io(c, 1'b1, lo, k);
    if (nd > 2'h0)
      byte_io(d[7:0], 1'b1, lo, k);
    if (nd > 2'h1)
      byte_io(d[15:8], 1'b1, lo, k);
    if (rd)
    begin
      start_cond();
      byte_io({a, 1'b1}, 1'b1, lo, k);
      byte_io(8'hff, 1'b0, lo, k);
      byte_io(8'hff, 1'b1, hi, k);
      q = {hi, lo};
    end
    #20 o_sda_oe = 1'b1;
    #45 scl_up();
    #60 o_sda_oe = 1'b0;
    #BUS_FREE_NS;
    if (c == cpt_pkg::CMD_STORE_USER_ALL && !rd)
      #STORE_WAIT_NS;
  endtask
endmodule // cpt_host

// File: cpt_target_port_bench.sv
// Self-checking bench for the management target port
`timescale 1ns/1ns
module cpt_target_port_bench;
  localparam int LIMIT = 40000;
  logic clk, resetn, h_scl_oe, h_sda_oe, d_scl_oe, d_sda_oe, alert_oe;
  logic single, busy, reen, cfg_wr, store, addr_ok, ack;
  logic [7:0] sel_hi, sel_lo, cfg_cmd;
  logic [6:0] faults, addr, me;
  logic [15:0] meas [7];
  logic [15:0] cfg_data, q;
  wire scl = !(h_scl_oe | d_scl_oe);
  wire sda = !(h_sda_oe | d_sda_oe);
  int num_errors, num_checks, cyc, n_st;
  // Short store wait keeps the run inside its budget
  cpt_host #(.STORE_WAIT_NS(20000)) host (.i_scl(scl), .i_sda(sda),
    .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
  cpt_target_port dut (.i_clk(clk), .i_resetn(resetn), .i_scl(scl),
    .o_scl_oe(d_scl_oe), .i_sda(sda), .o_sda_oe(d_sda_oe),
    .o_fault_alert_line_oe(alert_oe), .i_address_select_high(sel_hi),
    .i_address_select_low(sel_lo), .i_single_pin_address_option(single),
    .i_busy(busy), .i_fault_events(faults), .i_vout_reenable(reen),
    .i_vin(meas[0]), .i_vout(meas[1]), .i_iout(meas[2]),
    .i_temp_int(meas[3]), .i_temp_ext(meas[4]), .i_freq(meas[5]),
    .i_duty(meas[6]), .o_cfg_wr(cfg_wr), .o_cfg_cmd(cfg_cmd),
    .o_cfg_data(cfg_data), .o_store_req(store), .o_addr(addr),
    .o_addr_valid(addr_ok));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    n_st <= n_st + int'(store);
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Both pins always strapped; an open pin is never used
  function automatic logic [7:0] sel_code(input int i);
    return (i == 0) ? 8'h00 : cpt_pkg::SEL_THR[i - 1];
  endfunction
  task automatic rd(input logic [7:0] c);
    host.xfer(me, c, 2'h0, 16'h0000, 1'b1, q, ack);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(me, c, 2'h2, d, 1'b0, q, ack);
  endtask
  task automatic pulse_fault(input logic [6:0] f);
    @(posedge clk) faults <= f;
    @(posedge clk) faults <= 7'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_address();
    int hs[6] = '{0, 1, 1, 7, 2, 2};
    int ls[6] = '{0, 3, 4, 7, 5, 5};
    int e;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk) resetn <= 1'b0;
      sel_hi <= sel_code(hs[i]);
      sel_lo <= sel_code(ls[i]);
      single <= (i == 4);
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
      e = (i == 4) ? 8 * hs[i] : 8 * hs[i] + ls[i];
      if (e == 0 || e == 11 || e == 12)
        e = 127;
      chk({9'h000, addr}, 16'(e));
    end
    me = 7'(e);
    sel_lo <= sel_code(7);
    repeat (10) @(posedge clk);
    chk({9'h000, addr}, {9'h000, me});
    $display("test address done");
  endtask
  task automatic t_measure();
    logic [7:0] c[6] = '{8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h95, 8'h94};
    int ix[6] = '{0, 1, 2, 3, 5, 6};
    for (int i = 0; i < 6; i++)
    begin
      rd(c[i]);
      chk(q, meas[ix[i]]);
    end
    rd(cpt_pkg::CMD_PMBUS_REV);
    chk({8'h00, q[7:0]}, 16'h0033);
    wr(cpt_pkg::CMD_TEMP_SELECT, 16'h0001);
    chk({cfg_cmd, cfg_data[7:0]}, 16'hdc01);
    rd(cpt_pkg::CMD_READ_TEMP);
    chk(q, meas[4]);
    wr(cpt_pkg::CMD_ALERT_MASK, 16'h0008);
    rd(cpt_pkg::CMD_ALERT_MASK);
    chk(q, 16'h0008);
    wr(cpt_pkg::CMD_SINGLE_PIN, 16'h0001);
    chk({cfg_cmd, cfg_data[7:0]}, 16'hc901);
    rd(cpt_pkg::CMD_SINGLE_PIN);
    chk(q, 16'h0001);
    $display("test measure done");
  endtask
  task automatic t_alert();
    pulse_fault(7'h04);
    chk({15'h0000, alert_oe}, 16'h0001);
    rd(cpt_pkg::CMD_STATUS_BYTE);
    chk({8'h00, q[7:0]}, 16'h0004);
    host.xfer(me, cpt_pkg::CMD_CLEAR_FAULTS, 2'h0, 16'h0, 1'b0, q, ack);
    chk({15'h0000, alert_oe}, 16'h0000);
    pulse_fault(7'h08);
    chk({15'h0000, alert_oe}, 16'h0000);
    pulse_fault(7'h01);
    chk({15'h0000, alert_oe}, 16'h0001);
    @(posedge clk) reen <= 1'b1;
    @(posedge clk) reen <= 1'b0;
    repeat (4) @(posedge clk);
    chk({15'h0000, alert_oe}, 16'h0000);
    $display("test alert done");
  endtask
  task automatic t_store_refuse();
    int n;
    n = n_st;
    host.xfer(me, cpt_pkg::CMD_STORE_USER_ALL, 2'h0, 16'h0, 1'b0, q, ack);
    chk(16'(n_st - n), 16'h0001);
    host.xfer(7'h22, 8'h88, 2'h0, 16'h0, 1'b1, q, ack);
    chk({15'h0000, ack}, 16'h0000);
    @(posedge clk) busy <= 1'b1;
    fork
      wr(cpt_pkg::CMD_ALERT_MASK, 16'h0000);
      begin
        repeat (300) @(posedge clk);
        chk({15'h0000, d_scl_oe}, 16'h0001);
        busy <= 1'b0;
      end
    join
    chk({15'h0000, ack}, 16'h0001);
    $display("test store and refuse done");
  endtask
  initial
  begin
    resetn = 1'b0;
    busy = 1'b0;
    reen = 1'b0;
    faults = 7'h00;
    single = 1'b0;
    sel_hi = 8'h00;
    sel_lo = 8'h00;
    for (int i = 0; i < 7; i++)
      meas[i] = {8'(i + 1), 8'ha5};
    t_address();
    t_measure();
    t_alert();
    t_store_refuse();
    finish_test();
  end
endmodule // cpt_target_port_bench
